// ### src/rtt_timer.sv
// Auto-reload timer with 16-bit and split 8-bit modes on the SFR bus.
`timescale 1ns/100ps
module rtt_timer
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   output logic [7:0] sfr_rdata,
   input wire logic high_half_clock_select,
   input wire logic low_half_clock_select,
   input wire logic timer_irq_enable,
   input wire logic ext_osc,
   output logic irq_request
);

   //-------------------------------------------------------------------
   // State
   //-------------------------------------------------------------------

   // Control fields, the four data bytes, the registered read data and
   // the registered request all live in one packed record.
   typedef struct packed
   {
      logic high_overflow_flag;
      logic low_overflow_flag;
      logic low_interrupt_enable;
      logic split_control;
      logic run_control;
      logic external_clock_select;
      logic [7:0] timer_two_reload_low;
      logic [7:0] timer_two_reload_high;
      logic [7:0] timer_two_count_low;
      logic [7:0] timer_two_count_high;
      logic [7:0] rdata;
      logic irq;
   } rtt_state_t;

   rtt_state_t state;
   rtt_state_t next_state;

   // Every field leaves reset at its documented value: the timer is
   // stopped, both flags are clear and no request is pending.
   localparam rtt_state_t RESET_STATE =
   '{
      high_overflow_flag: 1'b0,
      low_overflow_flag: 1'b0,
      low_interrupt_enable: 1'b0,
      split_control: 1'b0,
      run_control: 1'b0,
      external_clock_select: 1'b0,
      timer_two_reload_low: rtt_pkg::RESET_BYTE,
      timer_two_reload_high: rtt_pkg::RESET_BYTE,
      timer_two_count_low: rtt_pkg::RESET_BYTE,
      timer_two_count_high: rtt_pkg::RESET_BYTE,
      rdata: rtt_pkg::RESET_BYTE,
      irq: 1'b0
   };

   // Tick strobes, decoded write strobes and the control read view.
   logic sys_div_tick;
   logic ext_div_tick;
   logic alt_tick;
   logic low_tick;
   logic high_tick;
   logic wr_control;
   logic wr_reload_low;
   logic wr_reload_high;
   logic wr_count_low;
   logic wr_count_high;
   logic [7:0] control_view;

   //-------------------------------------------------------------------
   // Clock sources
   //-------------------------------------------------------------------

   // System clock divided by twelve; it runs free, so a mode change
   // never restarts the alternate clock part way through a period.
   rtt_prescale u_prescale
   (
      .core_clk (core_clk),
      .reset (reset),
      .tick (sys_div_tick)
   );

   // External oscillator divided by eight, brought onto core_clk first.
   rtt_ext_tick u_ext_tick
   (
      .core_clk (core_clk),
      .reset (reset),
      .ext_osc (ext_osc),
      .tick (ext_div_tick)
   );

   // The alternate clock is shared by both halves; each half may instead
   // count on every system clock. Outside split mode the high half simply
   // follows the low half so its own select has no effect.
   always_comb
   begin
      alt_tick = state.external_clock_select ? ext_div_tick
                                             : sys_div_tick;
      low_tick = low_half_clock_select ? 1'b1 : alt_tick;
      if (state.split_control)
      begin
         high_tick = high_half_clock_select ? 1'b1 : alt_tick;
      end
      else
      begin
         high_tick = low_tick;
      end
   end

   //-------------------------------------------------------------------
   // Register decode
   //-------------------------------------------------------------------

   // Address decode for the five registers of the timer. Writes to any
   // other address are dropped without effect.
   always_comb
   begin
      wr_control = sfr_wr && (sfr_addr == rtt_pkg::ADDR_CONTROL);
      wr_reload_low = sfr_wr && (sfr_addr == rtt_pkg::ADDR_RELOAD_LOW);
      wr_reload_high = sfr_wr && (sfr_addr == rtt_pkg::ADDR_RELOAD_HIGH);
      wr_count_low = sfr_wr && (sfr_addr == rtt_pkg::ADDR_COUNT_LOW);
      wr_count_high = sfr_wr && (sfr_addr == rtt_pkg::ADDR_COUNT_HIGH);
   end

   // Read view of the control register; unused bits read as zero.
   always_comb
   begin
      control_view = 8'h00;
      control_view[rtt_pkg::BIT_HIGH_FLAG] = state.high_overflow_flag;
      control_view[rtt_pkg::BIT_LOW_FLAG] = state.low_overflow_flag;
      control_view[rtt_pkg::BIT_LOW_IRQ_EN] = state.low_interrupt_enable;
      control_view[rtt_pkg::BIT_SPLIT] = state.split_control;
      control_view[rtt_pkg::BIT_RUN] = state.run_control;
      control_view[rtt_pkg::BIT_EXT_SEL] = state.external_clock_select;
   end

   //-------------------------------------------------------------------
   // Next state
   //-------------------------------------------------------------------

   // Counting, reloads, flags, software writes and the read port. A
   // software write to a count register wins over a tick in the same
   // cycle, because software expects to see the value it wrote. A flag
   // set by hardware wins over a software clear in the same cycle, so
   // an overflow is never lost.
   always_comb
   begin
      logic set_high;
      logic set_low;
      logic [15:0] word_next;
      set_high = 1'b0;
      set_low = 1'b0;
      word_next = {state.timer_two_count_high, state.timer_two_count_low};
      next_state = state;

      if (!state.split_control)
      begin
         // One 16-bit counter, gated as a whole by the run bit.
         // The low byte's own rollover still raises the low flag.
         if (state.run_control && low_tick)
         begin
            set_low = (state.timer_two_count_low == rtt_pkg::BYTE_MAX);
            if (word_next == rtt_pkg::WORD_MAX)
            begin
               word_next = {state.timer_two_reload_high,
                            state.timer_two_reload_low};
               set_high = 1'b1;
            end
            else
            begin
               word_next = word_next + 16'h0001;
            end
         end
      end
      else
      begin
         // Low half ignores the run bit in split mode.
         if (low_tick)
         begin
            if (state.timer_two_count_low == rtt_pkg::BYTE_MAX)
            begin
               word_next[7:0] = state.timer_two_reload_low;
               set_low = 1'b1;
            end
            else
            begin
               word_next[7:0] = state.timer_two_count_low + 8'h01;
            end
         end
         // High half runs only while the run bit is set.
         if (state.run_control && high_tick)
         begin
            if (state.timer_two_count_high == rtt_pkg::BYTE_MAX)
            begin
               word_next[15:8] = state.timer_two_reload_high;
               set_high = 1'b1;
            end
            else
            begin
               word_next[15:8] = state.timer_two_count_high + 8'h01;
            end
         end
      end

      // Count registers: software writes take priority over counting.
      next_state.timer_two_count_low = wr_count_low ? sfr_wdata
                                                    : word_next[7:0];
      next_state.timer_two_count_high =
         wr_count_high ? sfr_wdata : word_next[15:8];

      // Reload registers.
      if (wr_reload_low)
      begin
         next_state.timer_two_reload_low = sfr_wdata;
      end
      if (wr_reload_high)
      begin
         next_state.timer_two_reload_high = sfr_wdata;
      end

      // Control register fields; bits 4 and 1 are not stored.
      if (wr_control)
      begin
         next_state.high_overflow_flag =
            sfr_wdata[rtt_pkg::BIT_HIGH_FLAG];
         next_state.low_overflow_flag =
            sfr_wdata[rtt_pkg::BIT_LOW_FLAG];
         next_state.low_interrupt_enable =
            sfr_wdata[rtt_pkg::BIT_LOW_IRQ_EN];
         next_state.split_control = sfr_wdata[rtt_pkg::BIT_SPLIT];
         next_state.run_control = sfr_wdata[rtt_pkg::BIT_RUN];
         next_state.external_clock_select =
            sfr_wdata[rtt_pkg::BIT_EXT_SEL];
      end
      // Hardware only ever sets the flags, and the set wins.
      if (set_high)
      begin
         next_state.high_overflow_flag = 1'b1;
      end
      if (set_low)
      begin
         next_state.low_overflow_flag = 1'b1;
      end

      // With the low enable set in 16-bit mode a full rollover raises
      // both flags at once; software is expected to keep that enable
      // clear there and must look at both flags to find the source.
      // Interrupt request follows the flags, not the vectoring, so it
      // stays high until software clears the flag that caused it (or the low enable, for the low flag) or timer_irq_enable drops.
      next_state.irq = timer_irq_enable &&
         (next_state.high_overflow_flag ||
          (next_state.low_interrupt_enable &&
           next_state.low_overflow_flag));

      // Registered read data; unmapped addresses read as zero.
      if (sfr_rd)
      begin
         unique case (sfr_addr)
            rtt_pkg::ADDR_CONTROL: next_state.rdata = control_view;
            rtt_pkg::ADDR_RELOAD_LOW:
               next_state.rdata = state.timer_two_reload_low;
            rtt_pkg::ADDR_RELOAD_HIGH:
               next_state.rdata = state.timer_two_reload_high;
            rtt_pkg::ADDR_COUNT_LOW:
               next_state.rdata = state.timer_two_count_low;
            rtt_pkg::ADDR_COUNT_HIGH:
               next_state.rdata = state.timer_two_count_high;
            default: next_state.rdata = 8'h00;
         endcase
      end
   end

   //-------------------------------------------------------------------
   // State register
   //-------------------------------------------------------------------

   // All registers take their documented reset values.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state <= RESET_STATE;
      end
      else
      begin
         state <= next_state;
      end
   end

   //-------------------------------------------------------------------
   // Outputs
   //-------------------------------------------------------------------

   // Both outputs come straight from the state register, so read data
   // and the request never glitch while the decode settles.
   assign sfr_rdata = state.rdata;
   assign irq_request = state.irq;

endmodule // rtt_timer

// ### src/rtt_pkg.sv
// Package with the register map, field positions and reset values.
//----------------------------------------------------------------------
//----------------------------------------------------------------------
package rtt_pkg;

   // Special function register addresses.
   localparam logic [7:0] ADDR_CONTROL = 8'hC8;
   localparam logic [7:0] ADDR_RELOAD_LOW = 8'hCA;
   localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hCB;
   localparam logic [7:0] ADDR_COUNT_LOW = 8'hCC;
   localparam logic [7:0] ADDR_COUNT_HIGH = 8'hCD;

   // Control register field positions.
   localparam int BIT_HIGH_FLAG = 7;
   localparam int BIT_LOW_FLAG = 6;
   localparam int BIT_LOW_IRQ_EN = 5;
   localparam int BIT_SPLIT = 3;
   localparam int BIT_RUN = 2;
   localparam int BIT_EXT_SEL = 0;

   // Reset values and rollover constants.
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] BYTE_MAX = 8'hFF;
   localparam logic [15:0] WORD_MAX = 16'hFFFF;

   // Cycle counts of the two dividers.
   localparam int SYS_DIVIDE = 12;
   localparam int EXT_DIVIDE = 8;
   localparam logic [3:0] SYS_DIV_LAST = 4'(SYS_DIVIDE - 1);
   localparam logic [2:0] EXT_DIV_LAST = 3'(EXT_DIVIDE - 1);

endpackage

// ### src/rtt_prescale.sv
// System clock divider that gives one tick in every twelve cycles.
`timescale 1ns/100ps
module rtt_prescale
(
   input wire logic core_clk,
   input wire logic reset,
   output logic tick
);

   typedef struct packed
   {
      logic [3:0] count;
      logic tick;
   } rtt_pre_state_t;

   rtt_pre_state_t state;
   rtt_pre_state_t next_state;

   // Free-running so the alternate clock phase never depends on the mode.
   always_comb
   begin
      next_state = state;
      next_state.tick = (state.count == rtt_pkg::SYS_DIV_LAST);
      if (state.count == rtt_pkg::SYS_DIV_LAST)
      begin
         next_state.count = 4'h0;
      end
      else
      begin
         next_state.count = state.count + 4'h1;
      end
   end

   // State register.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign tick = state.tick;

endmodule // rtt_prescale

// ### src/rtt_ext_tick.sv
// Synchroniser and divide-by-eight for the external oscillator.
`timescale 1ns/100ps
module rtt_ext_tick
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic ext_osc,
   output logic tick
);

   typedef struct packed
   {
      logic sync_a;
      logic sync_b;
      logic sync_c;
      logic level;
      logic [2:0] count;
      logic tick;
   } rtt_ext_state_t;

   rtt_ext_state_t state;
   rtt_ext_state_t next_state;

   // A change is accepted only when the second and third stages agree,
   // which filters a single metastable sample.
   always_comb
   begin
      next_state = state;
      next_state.sync_a = ext_osc;
      next_state.sync_b = state.sync_a;
      next_state.sync_c = state.sync_b;
      next_state.tick = 1'b0;
      if ((state.sync_b == state.sync_c) && (state.sync_b != state.level))
      begin
         next_state.level = state.sync_b;
         if (state.sync_b)
         begin
            next_state.count = state.count + 3'h1;
            next_state.tick = (state.count == rtt_pkg::EXT_DIV_LAST);
         end
      end
   end

   // State register.
   always_ff @(posedge core_clk)
   begin
      if (reset)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign tick = state.tick;

endmodule // rtt_ext_tick

// ### tb/rtt_timer_sva.sv
// Checker for the timer's register bus and interrupt request.
`timescale 1ns/100ps
module rtt_timer_chk
(
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic [7:0] sfr_wdata,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_rdata,
   input wire logic timer_irq_enable,
   input wire logic irq_request
);
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   logic mapped;
   logic clr_cause;
   // Only an enable drop or a control write may take the request away.
   assign mapped = sfr_addr inside {8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD};
   assign clr_cause = !timer_irq_enable || (sfr_wr && sfr_addr == 8'hC8);
   property p_irq_mask;
      !timer_irq_enable |=> !irq_request;
   endproperty
   a_irq_mask: assert property (p_irq_mask)
      else $error("request while disabled");
   property p_irq_set;
      sfr_wr && sfr_addr == 8'hC8 && sfr_wdata[7] && timer_irq_enable
         |=> irq_request;
   endproperty
   a_irq_set: assert property (p_irq_set)
      else $error("no request on high flag");
   property p_irq_hold;
      $fell(irq_request) |-> $past(clr_cause);
   endproperty
   a_irq_hold: assert property (p_irq_hold)
      else $error("flag cleared by hardware");
   property p_unmapped;
      sfr_rd && !mapped |=> sfr_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped read not zero");
   property p_spare_bits;
      sfr_rd && sfr_addr == 8'hC8 |=> !sfr_rdata[4] && !sfr_rdata[1];
   endproperty
   a_spare_bits: assert property (p_spare_bits)
      else $error("spare control bits not zero");
   property p_ctrl_rb;
      sfr_wr && sfr_addr == 8'hC8 ##1 !sfr_wr ##1
         sfr_rd && !sfr_wr && sfr_addr == 8'hC8
         |=> (sfr_rdata & 8'h2D) == ($past(sfr_wdata, 3) & 8'h2D);
   endproperty
   a_ctrl_rb: assert property (p_ctrl_rb)
      else $error("control readback wrong");
   property p_reload_rb;
      sfr_wr && sfr_addr inside {8'hCA, 8'hCB} ##1 !sfr_wr ##1
         sfr_rd && !sfr_wr && sfr_addr == $past(sfr_addr, 2)
         |=> sfr_rdata == $past(sfr_wdata, 3);
   endproperty
   a_reload_rb: assert property (p_reload_rb)
      else $error("reload readback wrong");
   property p_rdata_hold;
      !sfr_rd |=> $stable(sfr_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold)
      else $error("read data moved without a read");
endmodule // rtt_timer_chk

bind rtt_timer rtt_timer_chk i_rtt_timer_chk
(
   .core_clk(core_clk),
   .reset(reset),
   .sfr_addr(sfr_addr),
   .sfr_wr(sfr_wr),
   .sfr_wdata(sfr_wdata),
   .sfr_rd(sfr_rd),
   .sfr_rdata(sfr_rdata),
   .timer_irq_enable(timer_irq_enable),
   .irq_request(irq_request)
);

// ### tb/tb.sv
// Self-checking bench for the timer against a bench model.
`timescale 1ns/100ps
module tb;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_rdata;
   logic high_half_clock_select = 1'b0;
   logic low_half_clock_select = 1'b0;
   logic timer_irq_enable = 1'b0;
   logic ext_osc = 1'b0;
   logic irq_request;
   int errors = 0;
   int comparisons = 0;
   int lo, hi, rll, rlh, fh, fl, k, hs;
   logic [7:0] ctl;
   logic [7:0] regs [6] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9};

   rtt_timer i_rtt_timer
   (
      .core_clk(core_clk),
      .reset(reset),
      .sfr_addr(sfr_addr),
      .sfr_wr(sfr_wr),
      .sfr_wdata(sfr_wdata),
      .sfr_rd(sfr_rd),
      .sfr_rdata(sfr_rdata),
      .high_half_clock_select(high_half_clock_select),
      .low_half_clock_select(low_half_clock_select),
      .timer_irq_enable(timer_irq_enable),
      .ext_osc(ext_osc),
      .irq_request(irq_request)
   );

   // Half-period toggle gives the 50 ns system clock.
   always #25 core_clk = ~core_clk;

   task automatic end_of_test;
      $display("errors=%0d comparisons=%0d", errors, comparisons);
      if (errors == 0 && comparisons > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         errors++;
         $display("mismatch at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask

   // Strobes idle a cycle after each access, so no strobe is set twice.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge core_clk);
      sfr_wr = 1'b0;
      @(negedge core_clk);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
      sfr_addr = a;
      sfr_rd = 1'b1;
      @(negedge core_clk);
      sfr_rd = 1'b0;
      chk(sfr_rdata, e);
      @(negedge core_clk);
   endtask

   // One tick of a byte counter: reload and flag on rollover.
   task automatic bump(inout int c, input int r, inout int f);
      if (c == 255)
      begin
         c = r;
         f = 1;
      end
      else
         c++;
   endtask

   // The low byte refills from its reload only on a full-word rollover.
   task automatic tick16;
      int r;
      r = (hi == 255) ? rll : 0;
      if (lo == 255)
         bump(hi, rlh, fh);
      bump(lo, r, fl);
   endtask

   // Drives n rising edges on the oscillator pin at a quarter of core_clk,
   // then lets the synchroniser and divider settle.
   task automatic osc(input int n);
      repeat (n)
      begin
         ext_osc = 1'b1;
         repeat (2) @(negedge core_clk);
         ext_osc = 1'b0;
         repeat (2) @(negedge core_clk);
      end
      repeat (10) @(negedge core_clk);
   endtask

   // Main sequence; clock selects gate the ticks for an exact count.
   initial
   begin
      void'($urandom(32'h93F6));
      repeat (8) @(negedge core_clk);
      reset = 1'b0;
      foreach (regs[i])
         rd_chk(regs[i], 8'h00);
      for (int i = 1; i < 3; i++)
      begin
         k = $urandom_range(255);
         wr(regs[i], 8'(k));
         rd_chk(regs[i], 8'(k));
      end
      timer_irq_enable = 1'b1;
      wr(8'hC8, 8'hFF);
      rd_chk(8'hC8, 8'hED);
      chk({7'h00, irq_request}, 8'h01);
      timer_irq_enable = 1'b0;
      @(negedge core_clk);
      chk({7'h00, irq_request}, 8'h00);
      wr(8'hC8, 8'h12);
      rd_chk(8'hC8, 8'h00);
      timer_irq_enable = 1'b1;
      for (int t = 0; t < 10; t++)
      begin
         rll = $urandom_range(255);
         rlh = $urandom_range(255);
         lo = $urandom_range(255);
         hi = 254 + $urandom_range(1);
         k = $urandom_range(1, 300);
         hs = $urandom_range(1);
         fh = 0;
         fl = 0;
         ctl = {2'b00, t[0] & (t > 3), 1'b0, 1'(t > 3), t[1], 1'b0,
                1'b1};
         wr(8'hC8, ctl);
         wr(8'hCA, 8'(rll));
         wr(8'hCB, 8'(rlh));
         wr(8'hCC, 8'(lo));
         wr(8'hCD, 8'(hi));
         high_half_clock_select = 1'(hs);
         low_half_clock_select = 1'b1;
         repeat (k) @(negedge core_clk);
         low_half_clock_select = 1'b0;
         high_half_clock_select = 1'b0;
         for (int i = 0; i < k; i++)
            if (!ctl[3] && ctl[2])
               tick16();
            else if (ctl[3])
            begin
               bump(lo, rll, fl);
               if (ctl[2] && hs == 1)
                  bump(hi, rlh, fh);
            end
         rd_chk(8'hCC, 8'(lo));
         rd_chk(8'hCD, 8'(hi));
         rd_chk(8'hC8, {1'(fh), 1'(fl), ctl[5:0]});
         chk({7'h00, irq_request}, 8'(fh | (ctl[5] & fl)));
      end
      wr(8'hC8, 8'h00);
      wr(8'hCC, 8'h00);
      wr(8'hCD, 8'h00);
      wr(8'hC8, 8'h04);
      repeat (118) @(negedge core_clk);
      wr(8'hC8, 8'h01);
      rd_chk(8'hCC, 8'h0A);
      wr(8'hCC, 8'h00);
      wr(8'hC8, 8'h05);
      osc(24);
      wr(8'hC8, 8'h01);
      rd_chk(8'hCC, 8'h03);
      // Split mode with both halves on the shared oscillator clock.
      wr(8'hC8, 8'h0D);
      osc(8);
      rd_chk(8'hCC, 8'h04);
      rd_chk(8'hCD, 8'h01);
      end_of_test();
   end

   // Cuts a hang short well past the expected length of the run.
   initial
   begin
      repeat (20000) @(posedge core_clk);
      errors++;
      end_of_test();
   end
endmodule // tb
